// [src/pcg_pkg.sv]
// Shared constants and types for the power and clock gate control block.
package pcg_pkg;
   // Sizes.
   localparam int NUM_EP  = 16;
   localparam int NUM_RAM = 7;
   // Clock and timing.
   localparam int CLK_PERIOD_NS   = 20;
   localparam int RAM_WAKE_NS     = 20;
   localparam int RAM_WAKE_CYC_I  = (RAM_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] RAM_WAKE_CYC = (RAM_WAKE_CYC_I < 1) ? 4'h1 : 4'(RAM_WAKE_CYC_I);
   localparam logic [7:0] OSC_STABLE_CYC = 8'h40;
   localparam logic [7:0] OSC_CNT_LAST   = OSC_STABLE_CYC - 8'h01;
   // Reset values.
   localparam logic [NUM_EP-1:0] AWAKE_MASK_RST = 16'hFFFF;
   localparam logic [NUM_EP-1:0] SLEEP_MASK_RST = 16'hFFFF;
   // Dormant keyword, value is arbitrary.
   localparam logic [31:0] DORMANT_KEY = 32'h0D0E_A5E5;
   // Register offsets on the APB side.
   localparam logic [7:0] REG_PROC       = 8'h00;
   localparam logic [7:0] REG_AWAKE      = 8'h04;
   localparam logic [7:0] REG_SLEEP      = 8'h08;
   localparam logic [7:0] REG_DORM_RING  = 8'h0C;
   localparam logic [7:0] REG_DORM_XTAL  = 8'h10;
   localparam logic [7:0] REG_WAKE_CFG   = 8'h14;
   localparam logic [7:0] REG_RAM_PD     = 8'h18;
   localparam logic [7:0] REG_STATUS     = 8'h1C;
   // Field positions.
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_GPIO_EN  = 2;
   localparam int CFG_RTC_EN   = 3;
   localparam int CFG_OSC      = 4;
   localparam int PD_XIP       = 7;
   localparam int ST_HOLD      = 3;
   localparam int ST_RDY_LSB   = 4;
   localparam int ST_XIP       = 11;
   // Oscillator select, wake modes and power states.
   localparam logic OSC_RING = 1'b0;
   localparam logic OSC_XTAL = 1'b1;
   typedef enum logic [1:0] {
      PCG_LEVEL_LOW, PCG_LEVEL_HIGH, PCG_EDGE_FALL, PCG_EDGE_RISE
   } pcg_wake_mode_t;
   typedef enum logic [2:0] {
      PCG_AWAKE, PCG_SLEEP, PCG_WAKE_CLK, PCG_DORMANT, PCG_OSC_START
   } pcg_state_t;
endpackage

// [src/pcg_link_if.sv]
// Link between the power controller and the system side.
`timescale 1ns/1ps
interface pcg_link_if;
   import pcg_pkg::*;
   logic                 proc_asleep_0;
   logic                 proc_asleep_1;
   logic [1:0]           proc_irq;
   logic                 dma_busy;
   logic                 mask_wr;
   logic                 mask_sel;
   logic [NUM_EP-1:0]    mask_data;
   logic                 dormant_wr;
   logic                 dormant_osc;
   logic [31:0]          dormant_key;
   logic                 active_osc;
   pcg_wake_mode_t       wake_mode;
   logic                 gpio_wake_en;
   logic                 rtc_wake_en;
   logic [NUM_RAM-1:0]   ram_pd_req;
   logic                 xip_pd_req;
   pcg_state_t           power_state;
   logic                 bus_hold;
   logic [NUM_RAM-1:0]   ram_pd;
   logic [NUM_RAM-1:0]   ram_ready;
   logic                 xip_cache_en;

   modport device (
      input  proc_asleep_0, proc_asleep_1, proc_irq, dma_busy, mask_wr, mask_sel,
      input  mask_data, dormant_wr, dormant_osc, dormant_key, active_osc,
      input  wake_mode, gpio_wake_en, rtc_wake_en, ram_pd_req, xip_pd_req,
      output power_state, bus_hold, ram_pd, ram_ready, xip_cache_en
   );
   modport system (
      output proc_asleep_0, proc_asleep_1, proc_irq, dma_busy, mask_wr, mask_sel,
      output mask_data, dormant_wr, dormant_osc, dormant_key, active_osc,
      output wake_mode, gpio_wake_en, rtc_wake_en, ram_pd_req, xip_pd_req,
      input  power_state, bus_hold, ram_pd, ram_ready, xip_cache_en
   );
endinterface

// [src/pcg_power_ctrl.sv]
// Power controller: endpoint clock gates, sleep, dormant and memory power down.
// Behaviour
// - Every endpoint has its own enable, anytime.
// - Gate enables switch without glitches.
// - Gated peripherals resume without any reset.
// - Awake and sleep masks, one bit each.
// - Sleep needs both processors asleep, DMA idle.
// - Interrupt leaves sleep, awake mask returns.
// - Sleep mask drives gates during sleep.
// - Processors gate their own clocks themselves.
// - Bus held off until clocks re-enabled.
// - Software keeps fabric and stack memories awake.
// - Dormant stops every clock and oscillator; proc_clk_en is not gated by dormant.
// - Dormant wakes on GPIO event or RTC.
// - Oscillator restarts, ungated only once stable.
// - All state retained through dormant.
// - Software powers PLLs down around dormant.
// - Keyword to active oscillator enters dormant.
// - Software stops processor oscillator last.
// - Powered-down memory keeps contents, refuses access.
// - No memory access while powered down.
// - Wait 20 ns after memory power-up.
// - Powered-down cache gets no lookups.
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module pcg_power_ctrl
   import pcg_pkg::*;
(
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                reset,
   // Link to the system side
   pcg_link_if.device               link,
   // Wake sources
   input  wire logic                gpio_pin,
   input  wire logic                rtc_irq,
   // Clock tree
   output logic [NUM_EP-1:0]        ep_clk_en,
   output logic                     osc_run
);

   pcg_state_t          state;
   pcg_state_t          next_state;
   logic [NUM_EP-1:0]   awake_gate_mask;
   logic [NUM_EP-1:0]   sleep_gate_mask;
   logic [NUM_EP-1:0]   next_ep_clk_en;
   logic [7:0]          osc_cnt;
   logic                gpio_prev;
   logic [3:0]          ram_cnt [NUM_RAM];
   logic                dormant_hit;
   logic                sleep_ok;
   logic                irq_any;
   logic                wake_evt;

   // Decides whether the wake pin matches the selected event.
   function automatic logic gpio_wake_hit(input pcg_wake_mode_t mode,
                                          input logic cur,
                                          input logic prev);
      logic hit;
      hit = 1'b0;
      case (mode)
         PCG_LEVEL_LOW: begin
            hit = ~cur;
         end
         PCG_LEVEL_HIGH: begin
            hit = cur;
         end
         PCG_EDGE_FALL: begin
            hit = prev & ~cur;
         end
         PCG_EDGE_RISE: begin
            hit = ~prev & cur;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      return hit;
   endfunction

   assign irq_any = |link.proc_irq;

   assign sleep_ok = link.proc_asleep_0 & link.proc_asleep_1 & ~link.dma_busy & ~irq_any;

   assign dormant_hit = link.dormant_wr & (link.dormant_key == DORMANT_KEY) &
                        (link.dormant_osc == link.active_osc);

   assign wake_evt = (link.gpio_wake_en & gpio_wake_hit(link.wake_mode, gpio_pin, gpio_prev)) |
                     (link.rtc_wake_en & rtc_irq);

   // Wake pin history for edge detection.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         gpio_prev <= 1'b0;
      end else begin
         gpio_prev <= gpio_pin;
      end
   end

   // Next power state.
   always_comb begin
      next_state = state;
      case (state)
         PCG_AWAKE: begin
            if (dormant_hit) begin
               next_state = PCG_DORMANT;
            end else if (sleep_ok) begin
               next_state = PCG_SLEEP;
            end
         end
         PCG_SLEEP: begin
            if (irq_any) begin
               next_state = PCG_WAKE_CLK;
            end
         end
         PCG_WAKE_CLK: begin
            next_state = PCG_AWAKE;
         end
         PCG_DORMANT: begin
            if (wake_evt) begin
               next_state = PCG_OSC_START;
            end
         end
         PCG_OSC_START: begin
            if (osc_cnt == OSC_CNT_LAST) begin
               next_state = PCG_AWAKE;
            end
         end
         default: begin
            next_state = PCG_AWAKE;
         end
      endcase
   end

   // Power state register.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state <= PCG_AWAKE;
      end else begin
         state <= next_state;
      end
   end

   assign link.power_state = state;

   // Oscillator start-up counter.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         osc_cnt <= 8'h00;
      end else if (state == PCG_OSC_START) begin
         osc_cnt <= osc_cnt + 8'h01;
      end else begin
         osc_cnt <= 8'h00;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         osc_run <= 1'b1;
      end else begin
         osc_run <= (next_state != PCG_DORMANT);
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         awake_gate_mask <= AWAKE_MASK_RST;
         sleep_gate_mask <= SLEEP_MASK_RST;
      end else if (link.mask_wr) begin
         if (link.mask_sel) begin
            sleep_gate_mask <= link.mask_data;
         end else begin
            awake_gate_mask <= link.mask_data;
         end
      end
   end

   always_comb begin
      case (next_state)
         PCG_SLEEP: begin
            next_ep_clk_en = sleep_gate_mask;
         end
         PCG_DORMANT, PCG_OSC_START: begin
            next_ep_clk_en = '0;
         end
         default: begin
            next_ep_clk_en = awake_gate_mask;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ep_clk_en <= AWAKE_MASK_RST;
      end else begin
         ep_clk_en <= next_ep_clk_en;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         link.bus_hold <= 1'b0;
      end else begin
         link.bus_hold <= (next_state != PCG_AWAKE);
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         link.ram_pd    <= '0;
         link.ram_ready <= '1;
         for (int i = 0; i < NUM_RAM; i++) begin
            ram_cnt[i] <= RAM_WAKE_CYC;
         end
      end else begin
         link.ram_pd <= link.ram_pd_req;
         for (int i = 0; i < NUM_RAM; i++) begin
            if (link.ram_pd[i]) begin
               ram_cnt[i]        <= 4'h0;
               link.ram_ready[i] <= 1'b0;
            end else begin
               if (ram_cnt[i] != RAM_WAKE_CYC) begin
                  ram_cnt[i] <= ram_cnt[i] + 4'h1;
               end
               link.ram_ready[i] <= (ram_cnt[i] == RAM_WAKE_CYC) & ~link.ram_pd_req[i];
            end
         end
      end
   end

   // cache lookups off when powered down
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         link.xip_cache_en <= 1'b1;
      end else begin
         link.xip_cache_en <= ~link.xip_pd_req;
      end
   end

endmodule

// [src/pcg_system_side.sv]
// System side: APB registers, processor sleep, DMA and memory requests.
`timescale 1ns/1ps
module pcg_system_side
   import pcg_pkg::*;
(
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                reset,
   // Link to the power controller
   pcg_link_if.system               link,
   // APB slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   // Processor and DMA events
   input  wire logic [1:0]          irq_in,
   input  wire logic                dma_busy_in,
   // Processor clocks and memory access permission
   output logic [1:0]               proc_clk_en,
   output logic [NUM_RAM-1:0]       ram_access_ok
);

   logic [1:0]          proc_asleep;
   logic [NUM_EP-1:0]   awake_shadow;
   logic [NUM_EP-1:0]   sleep_shadow;
   logic [4:0]          wake_cfg;
   logic [7:0]          ram_retention_select;
   logic                access;
   logic                wr_now;
   logic                mapped;
   logic [31:0]         rd_val;

   assign access = psel & penable & ~pready & ~link.bus_hold;
   assign wr_now = psel & penable & pready & pwrite & ~pslverr;

   always_comb begin
      mapped = 1'b1;
      rd_val = 32'h0000_0000;
      case (paddr)
         REG_PROC:      rd_val[1:0] = proc_asleep;
         REG_AWAKE:     rd_val[NUM_EP-1:0] = awake_shadow;
         REG_SLEEP:     rd_val[NUM_EP-1:0] = sleep_shadow;
         REG_DORM_RING: rd_val = 32'h0000_0000;
         REG_DORM_XTAL: rd_val = 32'h0000_0000;
         REG_WAKE_CFG:  rd_val[4:0] = wake_cfg;
         REG_RAM_PD:    rd_val[7:0] = ram_retention_select;
         REG_STATUS: begin
            rd_val[2:0]                             = link.power_state;
            rd_val[ST_HOLD]                         = link.bus_hold;
            rd_val[ST_RDY_LSB +: NUM_RAM]           = link.ram_ready;
            rd_val[ST_XIP]                          = link.xip_cache_en;
         end
         default:       mapped = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= access;
         pslverr <= access & ~mapped;
         if (access & ~pwrite) begin
            prdata <= rd_val;
         end
      end
   end

   // processor sleep flags, wake interrupt wins
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         proc_asleep <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (irq_in[i]) begin
               proc_asleep[i] <= 1'b0;
            end else if (wr_now && paddr == REG_PROC && pwdata[i]) begin
               proc_asleep[i] <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         proc_clk_en <= 2'b11;
      end else begin
         proc_clk_en <= ~proc_asleep | irq_in;
      end
   end

   // Link event and status registers.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         link.proc_asleep_0 <= 1'b0;
         link.proc_asleep_1 <= 1'b0;
         link.proc_irq      <= 2'b00;
         link.dma_busy      <= 1'b0;
      end else begin
         link.proc_asleep_0 <= proc_asleep[0];
         link.proc_asleep_1 <= proc_asleep[1];
         link.proc_irq      <= irq_in;
         link.dma_busy      <= dma_busy_in;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         link.mask_wr   <= 1'b0;
         link.mask_sel  <= 1'b0;
         link.mask_data <= '0;
         awake_shadow   <= AWAKE_MASK_RST;
         sleep_shadow   <= SLEEP_MASK_RST;
      end else begin
         link.mask_wr <= wr_now & (paddr == REG_AWAKE || paddr == REG_SLEEP);
         if (wr_now && paddr == REG_AWAKE) begin
            link.mask_sel  <= 1'b0;
            link.mask_data <= pwdata[NUM_EP-1:0];
            awake_shadow   <= pwdata[NUM_EP-1:0];
         end else if (wr_now && paddr == REG_SLEEP) begin
            link.mask_sel  <= 1'b1;
            link.mask_data <= pwdata[NUM_EP-1:0];
            sleep_shadow   <= pwdata[NUM_EP-1:0];
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         link.dormant_wr  <= 1'b0;
         link.dormant_osc <= OSC_RING;
         link.dormant_key <= 32'h0000_0000;
      end else begin
         link.dormant_wr <= wr_now & (paddr == REG_DORM_RING || paddr == REG_DORM_XTAL);
         if (wr_now && (paddr == REG_DORM_RING || paddr == REG_DORM_XTAL)) begin
            link.dormant_osc <= (paddr == REG_DORM_XTAL) ? OSC_XTAL : OSC_RING;
            link.dormant_key <= pwdata;
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wake_cfg <= 5'h00;
      end else if (wr_now && paddr == REG_WAKE_CFG) begin
         wake_cfg <= pwdata[4:0];
      end
   end

   assign link.wake_mode    = pcg_wake_mode_t'(wake_cfg[CFG_MODE_LSB +: 2]);
   assign link.gpio_wake_en = wake_cfg[CFG_GPIO_EN];
   assign link.rtc_wake_en  = wake_cfg[CFG_RTC_EN];
   assign link.active_osc   = wake_cfg[CFG_OSC];

   // memory and cache power down requests
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ram_retention_select <= 8'h00;
      end else if (wr_now && paddr == REG_RAM_PD) begin
         ram_retention_select <= pwdata[7:0];
      end
   end

   assign link.ram_pd_req = ram_retention_select[NUM_RAM-1:0];
   assign link.xip_pd_req = ram_retention_select[PD_XIP];

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ram_access_ok <= '0;
      end else begin
         ram_access_ok <= link.ram_ready & ~link.ram_pd_req & ~link.ram_pd;
      end
   end

endmodule

// [sim/pcg_checker.sv]
// Concurrent checks on the link between the two power control ends.
`timescale 1ns/1ps
module pcg_checker
   import pcg_pkg::*;
(
   // Clock and reset
   input wire logic              core_clk,
   input wire logic              reset,
   // System to device
   input wire logic              proc_asleep_0,
   input wire logic              proc_asleep_1,
   input wire logic [1:0]        proc_irq,
   input wire logic              dma_busy,
   input wire logic              mask_wr,
   input wire logic              mask_sel,
   input wire logic [NUM_EP-1:0] mask_data,
   input wire logic              dormant_wr,
   input wire logic              dormant_osc,
   input wire logic [31:0]       dormant_key,
   input wire logic              active_osc,
   input wire logic [NUM_RAM-1:0] ram_pd_req,
   // Device to system
   input wire pcg_state_t        power_state,
   input wire logic              bus_hold,
   input wire logic [NUM_RAM-1:0] ram_pd,
   input wire logic [NUM_RAM-1:0] ram_ready,
   // Clock tree
   input wire logic [NUM_EP-1:0] ep_clk_en,
   input wire logic              osc_run
);
   logic [NUM_EP-1:0] am;
   logic [NUM_EP-1:0] sm;
   logic [7:0]        oc;

   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);

   // Shadow copies of the two gate masks.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         am <= AWAKE_MASK_RST;
         sm <= SLEEP_MASK_RST;
      end else if (mask_wr) begin
         if (mask_sel) begin
            sm <= mask_data;
         end else begin
            am <= mask_data;
         end
      end
   end

   // Counts the cycles spent waiting for the oscillator.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         oc <= 8'h00;
      end else if (power_state == PCG_OSC_START) begin
         oc <= oc + 8'h01;
      end else begin
         oc <= 8'h00;
      end
   end

   a_sleep_entry: assert property (power_state != PCG_SLEEP ##1 power_state == PCG_SLEEP
      |-> $past(proc_asleep_0 && proc_asleep_1 && !dma_busy)) else $error("bad sleep entry");
   a_sleep_mask: assert property (power_state == PCG_SLEEP && $stable(sm)
      |-> ep_clk_en == sm) else $error("sleep mask not applied");
   a_awake_mask: assert property (power_state == PCG_AWAKE && $past(power_state) == PCG_AWAKE
      && $stable(am) |-> ep_clk_en == am) else $error("awake mask not applied");
   a_wake_path: assert property (power_state == PCG_SLEEP && proc_irq != 2'h0
      |=> power_state == PCG_WAKE_CLK ##1 power_state == PCG_AWAKE) else $error("no wake");
   a_hold_bus: assert property (bus_hold == (power_state != PCG_AWAKE))
      else $error("bus hold wrong");
   a_dormant_off: assert property (power_state == PCG_DORMANT
      |-> ep_clk_en == '0 && !osc_run) else $error("clocks run in dormant");
   a_osc_gate: assert property (power_state == PCG_OSC_START
      |-> osc_run && ep_clk_en == '0) else $error("clock ungated early");
   a_osc_wait: assert property ($past(power_state) == PCG_OSC_START &&
      power_state == PCG_AWAKE |-> oc == OSC_STABLE_CYC) else $error("oscillator wait wrong");
   a_key_enter: assert property (power_state == PCG_AWAKE && dormant_wr &&
      dormant_key == DORMANT_KEY && dormant_osc == active_osc
      |=> power_state == PCG_DORMANT) else $error("dormant not entered");
   a_key_refuse: assert property (power_state == PCG_AWAKE && dormant_wr &&
      (dormant_key != DORMANT_KEY || dormant_osc != active_osc)
      |=> power_state != PCG_DORMANT) else $error("dormant entered wrongly");
   a_ram_down: assert property (1'b1 |=> ram_pd == $past(ram_pd_req)
      && (ram_pd & ram_ready) == '0) else $error("memory power down wrong");
   a_ram_wake: assert property ($fell(ram_pd[0]) |-> !ram_ready[0] ##[1:4] ram_ready[0])
      else $error("memory ready timing wrong");
endmodule

// [sim/tb.sv]
// Self-checking bench joining both power control ends.
`timescale 1ns/1ps
module tb;
   import pcg_pkg::*;
   logic               core_clk;
   logic               reset;
   logic               psel;
   logic               penable;
   logic               pwrite;
   logic [7:0]         paddr;
   logic [31:0]        pwdata;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   logic [1:0]         irq_in;
   logic               dma_busy_in;
   logic [1:0]         proc_clk_en;
   logic [NUM_RAM-1:0] ram_access_ok;
   logic               gpio_pin;
   logic               rtc_irq;
   logic [NUM_EP-1:0]  ep_clk_en;
   logic               osc_run;
   logic [31:0]        rd;
   logic               er;
   int                 n_errors;
   int                 checks_done;

   pcg_link_if link ();
   pcg_power_ctrl u_pcg_power_ctrl (.core_clk(core_clk), .reset(reset), .link(link),
      .gpio_pin(gpio_pin), .rtc_irq(rtc_irq), .ep_clk_en(ep_clk_en), .osc_run(osc_run));
   pcg_system_side u_pcg_system_side (.core_clk(core_clk), .reset(reset), .link(link),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_in(irq_in),
      .dma_busy_in(dma_busy_in), .proc_clk_en(proc_clk_en), .ram_access_ok(ram_access_ok));
   pcg_checker u_pcg_checker (.core_clk(core_clk), .reset(reset),
      .proc_asleep_0(link.proc_asleep_0), .proc_asleep_1(link.proc_asleep_1),
      .proc_irq(link.proc_irq), .dma_busy(link.dma_busy), .mask_wr(link.mask_wr),
      .mask_sel(link.mask_sel), .mask_data(link.mask_data), .dormant_wr(link.dormant_wr),
      .dormant_osc(link.dormant_osc), .dormant_key(link.dormant_key),
      .active_osc(link.active_osc), .ram_pd_req(link.ram_pd_req),
      .power_state(link.power_state), .bus_hold(link.bus_hold), .ram_pd(link.ram_pd),
      .ram_ready(link.ram_ready), .ep_clk_en(ep_clk_en), .osc_run(osc_run));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      if (n_errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic t_reset();
      check(ep_clk_en, 32'h0000_FFFF);
      apb(1'h0, REG_SLEEP, 32'h0);
      check(rd, 32'h0000_FFFF);
      apb(1'h0, REG_STATUS, 32'h0);
      check(rd, 32'h0000_0FF0);
      apb(1'h1, 8'h20, 32'h0000_5555);
      check(er, 32'h0000_0001);
      apb(1'h0, 8'h20, 32'h0);
      check(er, 32'h0000_0001);
      check(rd, 32'h0000_0000);
   endtask

   task automatic t_masks();
      apb(1'h1, REG_AWAKE, 32'h0000_1234);
      apb(1'h1, REG_SLEEP, 32'h0000_0021);
      cyc(3);
      check(ep_clk_en, 32'h0000_1234);
      apb(1'h0, REG_SLEEP, 32'h0);
      check(rd, 32'h0000_0021);
   endtask

   task automatic t_sleep();
      time t0;
      dma_busy_in <= 1'h1;
      apb(1'h1, REG_PROC, 32'h0000_0003);
      cyc(4);
      check(link.power_state, PCG_AWAKE);
      check(proc_clk_en, 32'h0);
      dma_busy_in <= 1'h0;
      cyc(4);
      check(link.power_state, PCG_SLEEP);
      check(ep_clk_en, 32'h0000_0021);
      t0 = $time;
      fork
         begin
            cyc(10);
            irq_in <= 2'h1;
         end
      join_none
      apb(1'h0, REG_AWAKE, 32'h0);
      check(($time - t0) > 200, 32'h1);
      check(rd, 32'h0000_1234);
      check(ep_clk_en, 32'h0000_1234);
      check(proc_clk_en, 32'h0000_0001);
      irq_in <= 2'h0;
   endtask

   task automatic t_dormant();
      logic        idle;
      logic [31:0] cfg;
      int          n;
      apb(1'h1, REG_DORM_RING, DORMANT_KEY ^ 32'h0000_0001);
      apb(1'h1, REG_DORM_XTAL, DORMANT_KEY);
      cyc(2);
      check(link.power_state, PCG_AWAKE);
      for (int i = 0; i < 5; i++) begin
         idle = (i == 0 || i == 2 || i == 4);
         cfg = (i == 4) ? 32'h0000_0018 : (32'(i) | 32'h0000_0004);
         gpio_pin <= idle;
         apb(1'h1, REG_WAKE_CFG, cfg);
         apb(1'h1, (i == 4) ? REG_DORM_XTAL : REG_DORM_RING, DORMANT_KEY);
         cyc(3);
         check(link.power_state, PCG_DORMANT);
         check({osc_run, ep_clk_en}, 32'h0);
         if (i == 4) begin
            rtc_irq <= 1'h1;
         end else begin
            gpio_pin <= !idle;
         end
         n = 0;
         do begin
            cyc(1);
            n++;
         end while (link.power_state !== PCG_AWAKE && n < 200);
         check(n, 32'(OSC_STABLE_CYC) + 32'h0000_0002);
         check(ep_clk_en, 32'h0000_1234);
         rtc_irq <= 1'h0;
         gpio_pin <= idle;
         cyc(2);
      end
   endtask

   task automatic t_ram();
      apb(1'h1, REG_RAM_PD, 32'h0000_0085);
      cyc(5);
      check(ram_access_ok, 32'h0000_007A);
      check(link.xip_cache_en, 32'h0);
      apb(1'h1, REG_RAM_PD, 32'h0);
      cyc(1);
      check(ram_access_ok, 32'h0000_007A);
      cyc(6);
      check(ram_access_ok, 32'h0000_007F);
      check(link.xip_cache_en, 32'h1);
   endtask

   initial begin
      core_clk = 1'h0;
      forever #10 core_clk = ~core_clk;
   end

   initial begin
      reset = 1'h1;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      irq_in = 2'h0;
      dma_busy_in = 1'h0;
      gpio_pin = 1'h1;
      rtc_irq = 1'h0;
      n_errors = 0;
      checks_done = 0;
      repeat (20) @(posedge core_clk);
      reset <= 1'h0;
      t_reset();
      t_masks();
      t_sleep();
      t_dormant();
      t_ram();
      wrap_up();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      wrap_up();
   end
endmodule
